/* File: flash_poll_pkg.sv */
package flash_poll_pkg;
   // clock and pin timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_STROBE_NS   = 70;
   localparam int T_RECOVER_NS  = 30;
   localparam logic [3:0] STROBE_CYC  = 4'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RECOVER_CYC = 4'((T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // extra read strobe cycles so the resynchronised data has settled
   localparam logic [3:0] SYNC_LAT    = 4'h4;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_ADDR    = 8'h04;
   localparam logic [7:0] OFS_WDATA   = 8'h08;
   localparam logic [7:0] OFS_RECOVER = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_RDATA   = 8'h14;
   // control fields
   localparam int CTRL_START = 0;
   localparam int CTRL_OP_LO = 1;
   localparam int CTRL_STOP  = 4;
   localparam int CTRL_AUTO  = 5;
   // status bit positions on the data lines
   localparam int POLL_BIT   = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int LIMIT_BIT  = 5;
   localparam int WINDOW_BIT = 3;
   localparam int ABORT_BIT  = 1;
   // reset values
   localparam logic [31:0] RECOVER_RESET = 32'h0000_0000;
   typedef enum logic [2:0] {
      OP_WRITE    = 3'b000,
      OP_READ     = 3'b001,
      OP_TOGGLE   = 3'b010,
      OP_DATAPOLL = 3'b011,
      OP_WINDOW   = 3'b100,
      OP_RESET    = 3'b101
   } op_t;
   typedef enum logic [2:0] {
      RES_NONE         = 3'b000,
      RES_OK           = 3'b001,
      RES_FAIL         = 3'b010,
      RES_ABORT        = 3'b011,
      RES_STOPPED      = 3'b100,
      RES_NOT_ACCEPTED = 3'b101
   } result_t;
endpackage

/* File: flash_cycle_if.sv */
`timescale 1ns/10ps
interface flash_cycle_if #(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 16
);
   logic              req;
   logic              we;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              ack;
   logic [DATA_W-1:0] rdata;
   modport ctl (output req, output we, output addr, output wdata, input ack, input rdata);
   modport eng (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

/* File: pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   // three stages; a new value counts only once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         dout <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) dout <= s3;
      end
   end
endmodule

/* File: flash_cycle.sv */
`timescale 1ns/10ps
module flash_cycle
   import flash_poll_pkg::*;
#(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 16
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   flash_cycle_if.eng             cyc,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe,
   input  wire logic [DATA_W-1:0] dq_sync
);
   typedef enum logic [1:0] {
      CY_IDLE   = 2'b00,
      CY_SETUP  = 2'b01,
      CY_STROBE = 2'b10,
      CY_GAP    = 2'b11
   } cy_state_t;
   cy_state_t  st;
   logic [3:0] cnt;
   logic       cnt_done;
   assign cnt_done = (cnt == 4'h1);
   // one bus cycle per request; the gap with both strobes high makes every read a separate cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= CY_IDLE;
         cnt <= 4'h0;
         flash_addr <= '0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         dq_out <= '0;
         dq_oe <= 1'b0;
         cyc.ack <= 1'b0;
         cyc.rdata <= '0;
      end else begin
         cyc.ack <= 1'b0;
         case (st)
            CY_IDLE: if (cyc.req && !cyc.ack) begin
               flash_addr <= cyc.addr;
               dq_out <= cyc.wdata;
               dq_oe <= cyc.we;
               flash_ce_n <= 1'b0;
               st <= CY_SETUP;
            end
            CY_SETUP: begin
               flash_we_n <= !cyc.we;
               flash_oe_n <= cyc.we;
               cnt <= cyc.we ? STROBE_CYC : 4'(STROBE_CYC + SYNC_LAT);
               st <= CY_STROBE;
            end
            CY_STROBE: if (cnt_done) begin
               if (!cyc.we) cyc.rdata <= dq_sync;
               flash_we_n <= 1'b1;
               flash_oe_n <= 1'b1;
               cnt <= RECOVER_CYC;
               st <= CY_GAP;
            end else begin
               cnt <= 4'(cnt - 4'h1);
            end
            CY_GAP: if (cnt_done) begin
               flash_ce_n <= 1'b1;
               dq_oe <= 1'b0;
               cyc.ack <= 1'b1;
               st <= CY_IDLE;
            end else begin
               cnt <= 4'(cnt - 4'h1);
            end
            default: st <= CY_IDLE;
         endcase
      end
   end
endmodule

/* File: flash_status_ctrl.sv */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module flash_status_ctrl
   import flash_poll_pkg::*;
#(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 16
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic [DATA_W-1:0]      dq_out,
   output logic                   dq_oe,
   input  wire logic [DATA_W-1:0] dq_in,
   input  wire logic              ready_busy_output
);
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_WRITE = 4'b0001,
      ST_READ  = 4'b0010,
      ST_TG1   = 4'b0011,
      ST_TG2   = 4'b0100,
      ST_TG3   = 4'b0101,
      ST_DP1   = 4'b0110,
      ST_DP2   = 4'b0111,
      ST_WIN   = 4'b1000,
      ST_RST   = 4'b1001
   } state_t;

   flash_cycle_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) cyc ();

   state_t            state;
   state_t            next_state;
   result_t           result;
   result_t           next_result;
   op_t               op;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] recover_reg;
   logic [DATA_W-1:0] last_read;
   logic              auto_reset;
   logic              stop_pend;
   logic              window_flag;
   logic              next_window_flag;
   logic [DATA_W-1:0] dq_sync;
   logic              ready_sync;

   // pins from the flash are asynchronous to pclk
   pin_sync #(.W(DATA_W)) u_dq_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (dq_in),
      .dout    (dq_sync)
   );

   pin_sync #(.W(1)) u_rb_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ready_busy_output),
      .dout    (ready_sync)
   );

   flash_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
      .pclk       (pclk),
      .presetn    (presetn),
      .cyc        (cyc.eng),
      .flash_addr (flash_addr),
      .flash_ce_n (flash_ce_n),
      .flash_oe_n (flash_oe_n),
      .flash_we_n (flash_we_n),
      .dq_out     (dq_out),
      .dq_oe      (dq_oe),
      .dq_sync    (dq_sync)
   );

   // apb decode; zero wait states, so pready is always high
   logic        setup_ph;
   logic        wr_acc;
   logic        sel_ctrl;
   logic        sel_addr;
   logic        sel_wdata;
   logic        sel_recover;
   logic        sel_status;
   logic        sel_rdata;
   logic        mapped;
   logic        busy;
   logic        start_req;
   logic        stop_req;
   logic [31:0] rd_mux;

   assign setup_ph    = psel && !penable;
   assign wr_acc      = psel && penable && pwrite;
   assign sel_ctrl    = (paddr[7:0] == OFS_CTRL);
   assign sel_addr    = (paddr[7:0] == OFS_ADDR);
   assign sel_wdata   = (paddr[7:0] == OFS_WDATA);
   assign sel_recover = (paddr[7:0] == OFS_RECOVER);
   assign sel_status  = (paddr[7:0] == OFS_STATUS);
   assign sel_rdata   = (paddr[7:0] == OFS_RDATA);
   assign mapped      = (paddr[11:8] == 4'h0) &&
                        (sel_ctrl || sel_addr || sel_wdata || sel_recover || sel_status || sel_rdata);
   assign busy        = (state != ST_IDLE);
   assign start_req   = wr_acc && mapped && sel_ctrl && pwdata[CTRL_START] && !busy;
   assign stop_req    = wr_acc && mapped && sel_ctrl && pwdata[CTRL_STOP];
   assign pready      = 1'b1;

   // read mux; unmapped reads give zero and an error
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (!mapped) begin
         rd_mux = 32'h0000_0000;
      end else if (sel_ctrl) begin
         rd_mux = {26'h0, auto_reset, 1'b0, op, 1'b0};
      end else if (sel_addr) begin
         rd_mux = 32'(addr_reg);
      end else if (sel_wdata) begin
         rd_mux = 32'(wdata_reg);
      end else if (sel_recover) begin
         rd_mux = 32'(recover_reg);
      end else if (sel_status) begin
         rd_mux = {26'h0, window_flag, ready_sync, result, busy};
      end else if (sel_rdata) begin
         rd_mux = 32'(last_read);
      end
   end

   // answer is latched in the setup cycle and stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= !mapped;
      end
   end

   // software registers; op and auto_reset may only change while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op <= OP_WRITE;
         auto_reset <= 1'b0;
         addr_reg <= '0;
         wdata_reg <= '0;
         recover_reg <= RECOVER_RESET[DATA_W-1:0];
      end else if (wr_acc && mapped && !busy) begin
         if (sel_ctrl) begin
            op <= op_t'(pwdata[CTRL_OP_LO+2:CTRL_OP_LO]);
            auto_reset <= pwdata[CTRL_AUTO];
         end
         if (sel_addr) addr_reg <= pwdata[ADDR_W-1:0];
         if (sel_wdata) wdata_reg <= pwdata[DATA_W-1:0];
         if (sel_recover) recover_reg <= pwdata[DATA_W-1:0];
      end
   end

   // a stop waits for the current bus cycle, then ends the poll
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_pend <= 1'b0;
      end else if (stop_req && busy) begin
         stop_pend <= 1'b1;
      end else if (!busy) begin
         stop_pend <= 1'b0;
      end
   end

   // every poll read uses the software address, so it can point at the last buffer word
   assign cyc.req   = busy;
   assign cyc.we    = (state == ST_WRITE) || (state == ST_RST);
   assign cyc.addr  = addr_reg;
   assign cyc.wdata = (state == ST_RST) ? recover_reg : wdata_reg;

   // flag tests on the word just read and the one before it
   logic toggling;
   logic limit_hit;
   logic aborted;
   logic poll_match;

   assign toggling   = (cyc.rdata[TOGGLE_BIT] != last_read[TOGGLE_BIT]);
   assign limit_hit  = cyc.rdata[LIMIT_BIT];
   assign aborted    = cyc.rdata[ABORT_BIT];
   assign poll_match = (cyc.rdata[POLL_BIT] == wdata_reg[POLL_BIT]);

   // failure either hands over to the recovery write or reports and stops
   state_t  fail_state;
   result_t fail_result;
   assign fail_state  = auto_reset ? ST_RST : ST_IDLE;
   assign fail_result = RES_FAIL;

   // polling sequencer; apart from leaving idle on a start write, transitions happen only when a bus cycle completes
   always_comb begin
      next_state = state;
      next_result = result;
      next_window_flag = window_flag;
      case (state)
         ST_IDLE: if (start_req) begin
            next_result = RES_NONE;
            case (op_t'(pwdata[CTRL_OP_LO+2:CTRL_OP_LO]))
               OP_WRITE:    next_state = ST_WRITE;
               OP_READ:     next_state = ST_READ;
               OP_TOGGLE:   next_state = ST_TG1;
               OP_DATAPOLL: next_state = ST_DP1;
               OP_WINDOW:   next_state = ST_TG1;
               OP_RESET:    next_state = ST_RST;
               default:     next_state = ST_IDLE;
            endcase
         end
         ST_WRITE, ST_READ: if (cyc.ack) begin
            next_state = ST_IDLE;
            next_result = RES_OK;
         end
         ST_TG1: if (cyc.ack) begin
            next_state = stop_pend ? ST_IDLE : ST_TG2;
            next_result = stop_pend ? RES_STOPPED : result;
         end
         ST_TG2: if (cyc.ack) begin
            if (op == OP_WINDOW) begin
               // the window flag is read only once the erase command shows as accepted
               next_state = toggling ? ST_WIN : ST_IDLE;
               next_result = toggling ? result : RES_NOT_ACCEPTED;
            end else if (!toggling) begin
               next_state = ST_IDLE;
               next_result = RES_OK;
            end else if (aborted) begin
               next_state = ST_IDLE;
               next_result = RES_ABORT;
            end else if (limit_hit) begin
               next_state = ST_TG3;
            end else if (stop_pend) begin
               next_state = ST_IDLE;
               next_result = RES_STOPPED;
            end else begin
               next_state = ST_TG1;
            end
         end
         ST_TG3: if (cyc.ack) begin
            next_state = toggling ? fail_state : ST_IDLE;
            next_result = toggling ? fail_result : RES_OK;
         end
         ST_DP1: if (cyc.ack) begin
            if (poll_match) begin
               next_state = ST_DP2; // completion bit may lead the other lines, so read again
            end else if (aborted) begin
               next_state = ST_IDLE;
               next_result = RES_ABORT;
            end else if (limit_hit) begin
               next_state = ST_DP2;
            end else if (stop_pend) begin
               next_state = ST_IDLE;
               next_result = RES_STOPPED;
            end
         end
         ST_DP2: if (cyc.ack) begin
            next_state = poll_match ? ST_IDLE : fail_state;
            next_result = poll_match ? RES_OK : fail_result;
         end
         ST_WIN: if (cyc.ack) begin
            next_state = ST_IDLE;
            next_window_flag = cyc.rdata[WINDOW_BIT];
            next_result = RES_OK;
         end
         ST_RST: if (cyc.ack) begin
            next_state = ST_IDLE;
            if (result == RES_NONE) next_result = RES_OK;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // state, result and the previous read word for toggle comparison
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         result <= RES_NONE;
         window_flag <= 1'b0;
         last_read <= '0;
      end else begin
         state <= next_state;
         result <= next_result;
         window_flag <= next_window_flag;
         if (cyc.ack && !cyc.we) last_read <= cyc.rdata;
      end
   end
endmodule

/* File: flash_dev_model.sv */
`timescale 1ns/10ps
module flash_dev_model #(
   parameter int          ADDR_W           = 21,
   parameter logic [15:0] SECTOR_ERASE_CMD = 16'h0030,
   parameter logic [15:0] CHIP_ERASE_CMD   = 16'h0010,
   parameter int          WINDOW_READS     = 30
) (
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              ce_n,
   input  wire logic              oe_n,
   input  wire logic              we_n,
   input  wire logic [15:0]       din,
   output logic      [15:0]       dq,
   output logic                   ready_busy_output
);
   // one array word stands for every address: enough for polling, not for data layout
   logic [15:0] arr        = 16'h0000;
   int          reads_left = 0;
   int          win_left   = 0;
   bit          lim        = 1'b0;
   bit          abt        = 1'b0;
   bit          tog        = 1'b0;
   logic        busy;
   // a stuck limit or abort keeps the device busy until a reset command
   assign busy = (reads_left > 0) || lim || abt;
   // open drain with pull-up: low only while an operation runs
   assign ready_busy_output = busy ? 1'b0 : 1'b1;
   initial dq = 16'h0000;
   // each read cycle shows status while busy, array data otherwise
   always @(negedge oe_n) begin
      if (!ce_n && busy) begin
         dq = {8'h00, ~arr[7], tog, lim, 1'b0, win_left == 0, tog, abt, 1'b0};
         tog = ~tog;
         if (!lim && !abt && reads_left > 0) reads_left--;
         if (win_left > 0) win_left--;
      end else if (!ce_n) begin
         dq = arr;
      end
   end
   // released lines float: show the inverse so a stale sample is caught
   always @(posedge oe_n) dq = ~dq;
   // reset command ends any failure; while busy other writes are ignored, except a sector erase while the window is open
   always @(posedge we_n) begin
      if (!ce_n && din == 16'h00F0) begin
         lim = 1'b0;
         abt = 1'b0;
         reads_left = 0;
      end else if (!ce_n && win_left > 0 && din == SECTOR_ERASE_CMD) begin
         win_left = WINDOW_READS;
      end else if (!ce_n && !busy && din == CHIP_ERASE_CMD) begin
         reads_left = WINDOW_READS;
         win_left = 0;
      end else if (!ce_n && !busy) begin
         if (|(din & ~arr)) lim = 1'b1;
         arr = arr & din;
      end
   end
endmodule

/* File: flash_status_ctrl_asserts.sv */
`timescale 1ns/10ps
module flash_status_ctrl_asserts
   import flash_poll_pkg::*;
#(
   parameter int ADDR_W = 21,
   parameter int DATA_W = 16
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic              flash_ce_n,
   input wire logic              flash_oe_n,
   input wire logic              flash_we_n,
   input wire logic [DATA_W-1:0] dq_out,
   input wire logic              dq_oe,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic              ready_busy_output
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // apb answers in the first access cycle
   property p_zero_wait; psel && penable |-> pready; endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("access phase without ready");
   // anything outside the six aligned words is unmapped
   property p_unmapped;
      psel && !penable && (paddr[11:8] != 4'h0 || paddr[7:0] > OFS_RDATA || paddr[1:0] != 2'b00)
      |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_mapped; psel && !penable && paddr == {4'h0, OFS_STATUS} |=> !pslverr; endproperty
   a_mapped: assert property (p_mapped) else $error("status access refused");
   // read strobe must cover sync latency so the sampled status is settled
   property p_read_strobe; $fell(flash_oe_n) |=> !flash_oe_n [*5] ##1 flash_oe_n; endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read strobe length wrong");
   property p_write_strobe; $fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n; endproperty
   a_write_strobe: assert property (p_write_strobe) else $error("write strobe length wrong");
   // status is driven by the device during reads, so the controller must be off the lines
   property p_no_fight; !flash_oe_n |-> !dq_oe && flash_we_n && !flash_ce_n; endproperty
   a_no_fight: assert property (p_no_fight) else $error("controller drives during read");
   property p_addr_hold; !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
   property p_idle_gap; $rose(flash_ce_n) |=> flash_ce_n; endproperty
   a_idle_gap: assert property (p_idle_gap) else $error("no idle cycle between cycles");
   property p_write_drive; !flash_we_n |-> dq_oe && !flash_ce_n; endproperty
   a_write_drive: assert property (p_write_drive) else $error("write without data drive");
   c_read: cover property ($fell(flash_oe_n));
   c_write: cover property ($fell(flash_we_n));
   c_refuse: cover property (psel && penable && pslverr);
endmodule
bind flash_status_ctrl flash_status_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_addr,
   .flash_ce_n, .flash_oe_n, .flash_we_n, .dq_out, .dq_oe, .dq_in, .ready_busy_output);

/* File: flash_status_ctrl_tb_top.sv */
`timescale 1ns/10ps
module flash_status_ctrl_tb_top
   import flash_poll_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, s;
   logic [20:0] flash_addr;
   logic        flash_ce_n, flash_oe_n, flash_we_n, dq_oe, rb, e;
   logic [15:0] dq_out, dq_in, fm_dq;
   int          n_errors = 0;
   int          check_count = 0;
   int          cycles = 0;
   // data lines: controller drives on writes, device otherwise
   assign dq_in = dq_oe ? dq_out : fm_dq;
   flash_status_ctrl #(.ADDR_W(21), .DATA_W(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .dq_out,
      .dq_oe, .dq_in, .ready_busy_output(rb));
   flash_dev_model #(.ADDR_W(21)) fm (.addr(flash_addr), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
      .we_n(flash_we_n), .din(dq_out), .dq(fm_dq), .ready_busy_output(rb));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task summarize;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // a hang anywhere ends up here
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         summarize();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // setup, then access held until pready is seen high at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {4'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      s = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task start(input op_t op, input logic auto_rst);
      apb(1'b1, OFS_CTRL, {26'h0, auto_rst, 1'b0, op, 1'b1});
   endtask
   // wait for idle, let the ready line settle through its synchroniser, then compare
   task finish_op(input result_t res, input logic rdy);
      for (int i = 0; i < 600; i++) begin
         apb(1'b0, OFS_STATUS, 32'h0);
         if (s[0] === 1'b0) break;
      end
      repeat (4) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0);
      check({27'h0, s[4:0]}, {27'h0, rdy, res, 1'b0});
   endtask
   task run(input op_t op, input logic auto_rst, input result_t res, input logic rdy);
      start(op, auto_rst);
      finish_op(res, rdy);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_STATUS, 32'h0);
      check({28'h0, s[3:0]}, 32'h0);
      apb(1'b0, OFS_RECOVER, 32'h0);
      check(s, RECOVER_RESET);
      // unmapped place is refused with zero data
      apb(1'b0, 8'h40, 32'h0);
      check({s[30:0], e}, 32'h1);
      apb(1'b1, OFS_RECOVER, 32'h0000_00F0);
      apb(1'b1, OFS_ADDR, 32'h0000_1234);
      fm.arr = 16'h5A3C;
      run(OP_READ, 1'b0, RES_OK, 1'b1);
      apb(1'b0, OFS_RDATA, 32'h0);
      check(s, 32'h0000_5A3C);
      fm.reads_left = 5;
      run(OP_TOGGLE, 1'b0, RES_OK, 1'b1);
      check({11'h0, flash_addr}, 32'h0000_1234);
      apb(1'b1, OFS_WDATA, 32'h0000_5A3C);
      fm.reads_left = 4;
      run(OP_DATAPOLL, 1'b0, RES_OK, 1'b1);
      run(OP_WINDOW, 1'b0, RES_NOT_ACCEPTED, 1'b1);
      fm.reads_left = 30;
      fm.win_left = 30;
      run(OP_WINDOW, 1'b0, RES_OK, 1'b0);
      check({31'h0, s[5]}, 32'h0);
      fm.win_left = 0;
      run(OP_WINDOW, 1'b0, RES_OK, 1'b0);
      check({31'h0, s[5]}, 32'h1);
      fm.reads_left = 0;
      // timing limit reached: poll fails, automatic reset restores reads
      fm.lim = 1'b1;
      run(OP_TOGGLE, 1'b1, RES_FAIL, 1'b1);
      check({31'h0, fm.lim}, 32'h0);
      // programming a one over a zero halts the device
      fm.arr = 16'h0F0F;
      apb(1'b1, OFS_WDATA, 32'h0000_00FF);
      run(OP_WRITE, 1'b0, RES_OK, 1'b0);
      run(OP_TOGGLE, 1'b1, RES_FAIL, 1'b1);
      run(OP_READ, 1'b0, RES_OK, 1'b1);
      apb(1'b0, OFS_RDATA, 32'h0);
      check(s, 32'h0000_000F);
      fm.abt = 1'b1;
      run(OP_TOGGLE, 1'b0, RES_ABORT, 1'b0);
      run(OP_RESET, 1'b0, RES_OK, 1'b1);
      // stop mid-poll, then a fresh poll must start over
      fm.reads_left = 1000;
      start(OP_TOGGLE, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h0000_0010);
      finish_op(RES_STOPPED, 1'b0);
      fm.reads_left = 0;
      run(OP_TOGGLE, 1'b0, RES_OK, 1'b1);
      summarize();
   end
endmodule
